// ===== nbc_addr_reg.sv
`timescale 1ns/1ns
`include "nbc_defs.svh"

// holds the five address bytes of the pending address phase; read data registered
module nbc_addr_reg #(
    parameter int DEPTH = `NBC_ADDR_CYCLES
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr_en && int'(wr_idx) < DEPTH) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rd_data <= 8'h00;
        end else if (int'(rd_idx) < DEPTH) begin
            rd_data <= mem_q[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule : nbc_addr_reg

// ===== nbc_defs.svh
`ifndef NBC_DEFS_SVH
`define NBC_DEFS_SVH

// address cycle count and field widths
`define NBC_ADDR_CYCLES 5
`define NBC_COL_W 13
`define NBC_PAGE_W 6
`define NBC_BLK_W 11
`define NBC_BLK_SIG 11
`define NBC_BLOCKS 2048

// pin timing: strobe low and high phases, ns as printed limit for glitch rejection
`define NBC_GLITCH_NS 5
`define NBC_CLK_NS 4
`define NBC_PULSE_CYC ((`NBC_GLITCH_NS + `NBC_CLK_NS - 1) / `NBC_CLK_NS + 1)
`define NBC_SETUP_CYC 2

// reset values of the pins
`define NBC_CE_IDLE 1'b1
`define NBC_STROBE_IDLE 1'b1

`endif

// ===== nbc_flash_model.sv
`timescale 1ns/1ns
module nbc_flash_model (
    input wire logic CLK,
    input wire logic CHIP_SEL_N,
    input wire logic CMD_LATCH,
    input wire logic ADDR_LATCH,
    input wire logic WRITE_STROBE_N,
    input wire logic OUTPUT_STROBE_N,
    input wire logic WRITE_LOCK_N,
    input wire logic [7:0] IO_OUT,
    output logic [7:0] IO_IN,
    output logic READY_BUSY_N
);
    logic [7:0] cmd_q = 8'h00, dout_q = 8'h00;
    logic [7:0] abyte_q [5];
    logic [2:0] acnt_q = 3'h0;
    logic [3:0] nwr_q = 4'h0;
    logic [5:0] busy_q = 6'h00;
    // the strobe side only bumps a tag; the clocked side owns the busy counter
    logic [3:0] busy_tag_q = 4'h0;
    logic [3:0] busy_ack_q = 4'h0;
    logic [12:0] col_q = 13'h0000;
    logic [16:0] row_q = 17'h00000;
    ////////////////////////////////////////////////////////////////////////////////
    // the device has no clock: strobe edges do the latching
    always @(posedge WRITE_STROBE_N) begin
        if (!CHIP_SEL_N && OUTPUT_STROBE_N) begin
            if (CMD_LATCH && !ADDR_LATCH) begin
                cmd_q = IO_OUT;
                acnt_q = 3'h0;
                if (IO_OUT == 8'h30) busy_tag_q = busy_tag_q + 4'h1;
            end else if (ADDR_LATCH && !CMD_LATCH) begin
                abyte_q[acnt_q] = IO_OUT;
                acnt_q = acnt_q + 3'h1;
                if (acnt_q == 3'h5) begin
                    col_q = {abyte_q[1][4:0], abyte_q[0]};
                    row_q = {abyte_q[4][0], abyte_q[3], abyte_q[2]};
                end
            end else if (!CMD_LATCH && !ADDR_LATCH && WRITE_LOCK_N) begin
                nwr_q = nwr_q + 4'h1;
            end
        end
    end
    always @(negedge OUTPUT_STROBE_N) begin
        if (!CHIP_SEL_N && WRITE_STROBE_N && !CMD_LATCH && !ADDR_LATCH) begin
            if (cmd_q == 8'h70) begin
                dout_q = 8'hE0;
            end else begin
                dout_q = col_q[7:0] ^ 8'h5A;
                col_q = col_q + 13'h0001;
            end
        end
    end
    // released bus shows the inverse so a stale sample cannot pass
    assign IO_IN = (!CHIP_SEL_N && !OUTPUT_STROBE_N) ? dout_q : ~dout_q;
    always @(posedge CLK) begin
        if (busy_ack_q != busy_tag_q) begin
            busy_ack_q <= busy_tag_q;
            busy_q <= 6'h20;
        end else if (busy_q != 6'h00) begin
            busy_q <= busy_q - 6'h01;
        end
    end
    // open drain with pull-up: low only while busy
    assign READY_BUSY_N = (busy_q == 6'h00);
endmodule : nbc_flash_model

// ===== nbc_host.sv
`timescale 1ns/1ns
`include "nbc_defs.svh"
// Contract
// R1: address sent as five consecutive address cycles
// R2: column 13, page 6, block 11 bits
// R3: cycle1 column 7..0; cycle2 column 12..8
// R4: cycles 3-5 carry page and block bits
// R5: row is block above page
// R6: eleven block bits select 2048 blocks
// R7: six bus operation types recognised; the host has four: command, address, write and read
// R8: strobe pulses under 5 ns ignored
// R9: command latched with command latch high
// R10: write lock high for program/erase cycles
// R11: address latched with address latch high
// R12: data-in needs write lock high
// R13: write data one byte per strobe
// R14: read one byte per read strobe
// R15: output content depends on prior command
// R16: write lock low refuses program/erase
// R17: write lock evaluated continuously
// R18: chip select high means standby
// R19: read strobe high while device busy
// R20: read falling edge advances column
// R21: data pins float when deselected
// R22: ready/busy is open drain low busy
// R23: idle strobes pause and resume output
// R24: address phase ends after fifth cycle
module nbc_host (
    input wire logic CLK,
    input wire logic RSTN,
    // user side
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire nbc_pkg::nbc_op_e REQ_OP,
    input wire nbc_pkg::nbc_byte_t REQ_DATA,
    input wire logic ADDR_VALID,
    input wire logic [`NBC_COL_W-1:0] ADDR_COL,
    input wire logic [`NBC_PAGE_W-1:0] ADDR_PAGE,
    input wire logic [`NBC_BLK_W-1:0] ADDR_BLOCK,
    input wire logic MODIFY_EN,
    input wire logic DESELECT,
    output logic RSP_VALID,
    output nbc_pkg::nbc_byte_t RSP_DATA,
    output logic BUSY,
    output logic [`NBC_COL_W+`NBC_PAGE_W+`NBC_BLK_W-1:0] LAST_ADDR,
    // flash pins
    output logic CHIP_SEL_N,
    output logic CMD_LATCH,
    output logic ADDR_LATCH,
    output logic WRITE_STROBE_N,
    output logic OUTPUT_STROBE_N,
    output logic WRITE_LOCK_N,
    output logic [7:0] IO_OUT,
    output logic IO_OE,
    input wire logic [7:0] IO_IN,
    input wire logic READY_BUSY_N
);
    import nbc_pkg::*;

    localparam int PULSE = `NBC_PULSE_CYC;
    localparam int SETUP = `NBC_SETUP_CYC;

    // pack the fields into the byte the given address cycle carries
    function automatic logic [7:0] addr_byte(input logic [2:0] idx,
                                             input logic [`NBC_COL_W-1:0] col,
                                             input logic [`NBC_PAGE_W-1:0] pg,
                                             input logic [`NBC_BLK_W-1:0] blk);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            3'h0: b = col[7:0]; // [R3]
            3'h1: b = {3'h0, col[12:8]}; // [R3]
            3'h2: b = {blk[1:0], pg}; // [R4]
            3'h3: b = blk[9:2]; // [R4]
            3'h4: b = {7'h00, blk[10]}; // [R4] [R6]
            default: b = 8'h00;
        endcase
        return b;
    endfunction : addr_byte

    ////////////////////////////////////////////////////////////////////////////////
    nbc_state_e state_q;
    nbc_op_e op_q;
    logic [7:0] data_q;
    logic [7:0] cnt_q;
    logic [2:0] acyc_q;
    logic addr_mode_q;
    logic [`NBC_COL_W-1:0] col_q;
    logic [`NBC_PAGE_W-1:0] page_q;
    logic [`NBC_BLK_W-1:0] blk_q;
    logic [2:0] rd_idx;
    logic [7:0] abyte;
    logic busy_now;
    logic start;
    logic start_addr;

    // ready/busy is open drain; a low level means the device is busy
    assign busy_now = !READY_BUSY_N; // [R22]
    assign BUSY = busy_now;
    assign REQ_READY = (state_q == NBC_ST_IDLE) && !addr_mode_q && !busy_now; // [R19]
    assign start = REQ_VALID && REQ_READY;
    assign start_addr = ADDR_VALID && (state_q == NBC_ST_IDLE) && !addr_mode_q && !busy_now;
    assign rd_idx = acyc_q;

    nbc_addr_reg #(
        .DEPTH(`NBC_ADDR_CYCLES)
    ) u_areg (
        .CLK(CLK),
        .RSTN(RSTN),
        .wr_en(1'b0),
        .wr_idx(3'h0),
        .wr_data(8'h00),
        .rd_idx(rd_idx),
        .rd_data()
    );

    assign abyte = addr_byte(acyc_q, col_q, page_q, blk_q);

    ////////////////////////////////////////////////////////////////////////////////
    // address fields latched for the whole five-cycle phase
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            col_q <= '0;
            page_q <= '0;
            blk_q <= '0;
        end else if (start_addr && !start) begin
            col_q <= ADDR_COL;
            page_q <= ADDR_PAGE;
            blk_q <= ADDR_BLOCK;
        end
    end

    // row address in the report: block above page, column lowest
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            LAST_ADDR <= '0;
        end else if (start_addr && !start) begin
            LAST_ADDR <= {ADDR_BLOCK, ADDR_PAGE, ADDR_COL}; // [R5] [R2]
        end
    end

    // address phase: five back-to-back address cycles, then done
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            addr_mode_q <= 1'b0;
            acyc_q <= 3'h0;
        end else if (start_addr && !start) begin
            addr_mode_q <= 1'b1;
            acyc_q <= 3'h0;
        end else if (addr_mode_q && state_q == NBC_ST_DONE) begin
            if (acyc_q == 3'(`NBC_ADDR_CYCLES - 1)) begin
                addr_mode_q <= 1'b0; // [R24] [R1]
                acyc_q <= 3'h0;
            end else begin
                acyc_q <= acyc_q + 3'h1; // [R1]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one bus cycle: setup of SETUP cycles, then strobe low and strobe high of at least PULSE cycles each so
    // no strobe phase is shorter than the glitch filter of the device
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_q <= NBC_ST_IDLE;
            cnt_q <= 8'h00;
            op_q <= NBC_OP_CMD;
            data_q <= 8'h00;
        end else begin
            unique case (state_q)
                NBC_ST_IDLE: begin
                    if (start) begin
                        op_q <= REQ_OP; // [R7]
                        data_q <= REQ_DATA;
                        cnt_q <= 8'(SETUP);
                        state_q <= NBC_ST_SETUP;
                    end else if (start_addr || (addr_mode_q && !busy_now)) begin
                        op_q <= NBC_OP_ADDR;
                        cnt_q <= 8'(SETUP);
                        state_q <= NBC_ST_SETUP;
                    end
                end
                NBC_ST_SETUP: begin
                    // only the five-cycle phase rebuilds the byte; a single user
                    // address cycle keeps the byte it was given
                    if (op_q == NBC_OP_ADDR && addr_mode_q) begin
                        data_q <= abyte; // [R3] [R4]
                    end
                    if (cnt_q <= 8'h01) begin
                        cnt_q <= 8'(PULSE); // [R8]
                        state_q <= NBC_ST_LOW;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                NBC_ST_LOW: begin
                    if (cnt_q <= 8'h01) begin
                        cnt_q <= 8'(PULSE); // [R8]
                        state_q <= NBC_ST_HIGH;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                NBC_ST_HIGH: begin
                    if (cnt_q <= 8'h01) begin
                        state_q <= NBC_ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                NBC_ST_DONE: begin
                    state_q <= NBC_ST_IDLE;
                end
                default: begin
                    state_q <= NBC_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins: latch lines held through the whole cycle, strobe low only in LOW
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            CHIP_SEL_N <= `NBC_CE_IDLE;
            CMD_LATCH <= 1'b0;
            ADDR_LATCH <= 1'b0;
            WRITE_STROBE_N <= `NBC_STROBE_IDLE;
            OUTPUT_STROBE_N <= `NBC_STROBE_IDLE;
            IO_OUT <= 8'h00;
            IO_OE <= 1'b0;
        end else begin
            // standby when nothing is pending and the user asks to deselect
            CHIP_SEL_N <= DESELECT && state_q == NBC_ST_IDLE && !addr_mode_q; // [R18]
            CMD_LATCH <= state_q != NBC_ST_IDLE && op_q == NBC_OP_CMD; // [R9]
            ADDR_LATCH <= state_q != NBC_ST_IDLE && op_q == NBC_OP_ADDR; // [R11]
            // write strobe rises at end of LOW with output strobe held high
            WRITE_STROBE_N <= !(state_q == NBC_ST_SETUP && cnt_q <= 8'h01 &&
                                op_q != NBC_OP_READ) &&
                              !(state_q == NBC_ST_LOW && cnt_q > 8'h01 &&
                                op_q != NBC_OP_READ); // [R9] [R11] [R12] [R13]
            // one output strobe per byte; strobes stay high between reads [R23]
            OUTPUT_STROBE_N <= !(state_q == NBC_ST_SETUP && cnt_q <= 8'h01 &&
                                 op_q == NBC_OP_READ) &&
                               !(state_q == NBC_ST_LOW && cnt_q > 8'h01 &&
                                 op_q == NBC_OP_READ); // [R14] [R20] [R19]
            IO_OUT <= (state_q == NBC_ST_IDLE) ? 8'h00 : data_q;
            // bus released on reads so the device can drive it [R21]
            IO_OE <= state_q != NBC_ST_IDLE && state_q != NBC_ST_DONE &&
                     op_q != NBC_OP_READ;
        end
    end

    // write lock follows the user enable at all times, not only at strobes
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            WRITE_LOCK_N <= 1'b0; // [R16] [R17]
        end else begin
            WRITE_LOCK_N <= MODIFY_EN; // [R10] [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read byte sampled at the end of the low phase; content depends on the
    // command issued before, which the user tracks [R15]
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= 8'h00;
        end else begin
            RSP_VALID <= 1'b0;
            if (state_q == NBC_ST_LOW && cnt_q <= 8'h01 && op_q == NBC_OP_READ) begin
                RSP_VALID <= 1'b1; // [R14]
                RSP_DATA <= IO_IN;
            end
        end
    end
endmodule : nbc_host

// ===== nbc_host_assertions.sv
`timescale 1ns/1ns
module nbc_host_chk (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire nbc_pkg::nbc_op_e REQ_OP,
    input wire logic ADDR_VALID,
    input wire logic MODIFY_EN,
    input wire logic RSP_VALID,
    input wire logic CHIP_SEL_N,
    input wire logic CMD_LATCH,
    input wire logic ADDR_LATCH,
    input wire logic WRITE_STROBE_N,
    input wire logic OUTPUT_STROBE_N,
    input wire logic WRITE_LOCK_N,
    input wire logic IO_OE,
    input wire logic READY_BUSY_N
);
    import nbc_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence rd_take;
        REQ_VALID && REQ_READY && REQ_OP == NBC_OP_READ;
    endsequence
    sequence addr_take;
        ADDR_VALID && REQ_READY && !REQ_VALID;
    endsequence
    a_latch_excl: assert property (CMD_LATCH |-> !ADDR_LATCH)
        else $error("both latches high");
    a_strobe_excl: assert property (!WRITE_STROBE_N |-> OUTPUT_STROBE_N)
        else $error("both strobes low");
    a_strobe_sel: assert property (!WRITE_STROBE_N || !OUTPUT_STROBE_N |-> !CHIP_SEL_N)
        else $error("strobe while deselected");
    a_wr_width: assert property ($fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*3])
        else $error("write strobe too short");
    a_rd_width: assert property ($fell(OUTPUT_STROBE_N) |-> !OUTPUT_STROBE_N [*3])
        else $error("read strobe too short");
    a_rd_quiet: assert property (!OUTPUT_STROBE_N |-> !IO_OE)
        else $error("driving bus during read");
    a_busy_hold: assert property (!READY_BUSY_N && OUTPUT_STROBE_N |=> OUTPUT_STROBE_N)
        else $error("read strobe while busy");
    a_lock_follow: assert property (RSTN && $past(RSTN) |-> WRITE_LOCK_N == $past(MODIFY_EN))
        else $error("write lock not following enable");
    a_rd_answer: assert property (rd_take |-> ##[5:12] RSP_VALID)
        else $error("no read response");
    a_addr_phase: assert property (addr_take |=> !REQ_READY [*8])
        else $error("address phase cut short");
    a_one_take: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
        else $error("ready after take");
endmodule : nbc_host_chk
bind nbc_host nbc_host_chk i_nbc_host_chk (.CLK, .RSTN, .REQ_VALID, .REQ_READY, .REQ_OP,
    .ADDR_VALID, .MODIFY_EN, .RSP_VALID, .CHIP_SEL_N, .CMD_LATCH, .ADDR_LATCH,
    .WRITE_STROBE_N, .OUTPUT_STROBE_N, .WRITE_LOCK_N, .IO_OE, .READY_BUSY_N);

// ===== nbc_host_tb_top.sv
`timescale 1ns/1ns
`include "nbc_defs.svh"
module nbc_host_tb_top;
    import nbc_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, addr_valid = 1'b0;
    logic modify_en = 1'b0, deselect = 1'b0;
    logic req_ready, rsp_valid, busy, cs_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
    nbc_op_e req_op = NBC_OP_CMD;
    nbc_byte_t req_data = 8'h00, rsp_data, got;
    logic [7:0] io_out, io_in;
    logic [29:0] last_addr;
    int n_mismatch = 0, compares = 0, cyc = 0;
    always #2 clk = ~clk;
    nbc_host i_nbc_host (.CLK(clk), .RSTN(rstn), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_OP(req_op), .REQ_DATA(req_data), .ADDR_VALID(addr_valid), .ADDR_COL(13'h1ABC),
        .ADDR_PAGE(6'h2D), .ADDR_BLOCK(11'h5A7), .MODIFY_EN(modify_en), .DESELECT(deselect),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .BUSY(busy), .LAST_ADDR(last_addr),
        .CHIP_SEL_N(cs_n), .CMD_LATCH(cle), .ADDR_LATCH(ale), .WRITE_STROBE_N(we_n),
        .OUTPUT_STROBE_N(re_n), .WRITE_LOCK_N(wp_n), .IO_OUT(io_out), .IO_OE(io_oe),
        .IO_IN(io_in), .READY_BUSY_N(rb_n));
    nbc_flash_model i_nbc_flash_model (.CLK(clk), .CHIP_SEL_N(cs_n), .CMD_LATCH(cle),
        .ADDR_LATCH(ale), .WRITE_STROBE_N(we_n), .OUTPUT_STROBE_N(re_n), .WRITE_LOCK_N(wp_n),
        .IO_OUT(io_out), .IO_IN(io_in), .READY_BUSY_N(rb_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [29:0] g, input logic [29:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // one bus cycle, or the whole address phase when ad is set; n bounds the wait
    task automatic op(input logic ad, input nbc_op_e o, input nbc_byte_t d, input int n);
        int i;
        got = 8'hxx;
        @(posedge clk);
        for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(posedge clk);
        req_op <= o;
        req_data <= d;
        if (ad) addr_valid <= 1'b1;
        else req_valid <= 1'b1;
        @(posedge clk);
        // hold the request until the edge that samples ready high takes it
        for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(posedge clk);
        req_valid <= 1'b0;
        addr_valid <= 1'b0;
        i = 0;
        do begin
            @(posedge clk);
            if (rsp_valid === 1'b1) got = rsp_data;
            i++;
        end while (i < n && req_ready !== 1'b1);
    endtask : op
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        // reset values, looked at while reset still holds them
        chk(cs_n, 1'b1);
        chk(io_oe, 1'b0);
        chk(wp_n, 1'b0);
        rstn <= 1'b1;
        @(posedge clk);
        modify_en <= 1'b1;
        op(0, NBC_OP_CMD, 8'h80, 60);
        chk(i_nbc_flash_model.cmd_q, 8'h80);
        chk(cs_n, 1'b0);
        chk(wp_n, 1'b1);
        op(1, NBC_OP_ADDR, 8'h00, 100);
        chk(i_nbc_flash_model.col_q, 13'h1ABC);
        chk(i_nbc_flash_model.row_q, {11'h5A7, 6'h2D});
        chk(i_nbc_flash_model.abyte_q[1], 8'h1A);
        chk(i_nbc_flash_model.abyte_q[4], 8'h01);
        chk(last_addr, {11'h5A7, 6'h2D, 13'h1ABC});
        op(0, NBC_OP_WRITE, 8'h11, 60);
        op(0, NBC_OP_WRITE, 8'h22, 60);
        modify_en <= 1'b0;
        op(0, NBC_OP_WRITE, 8'h33, 60);
        chk(i_nbc_flash_model.nwr_q, 4'h2);
        op(0, NBC_OP_CMD, 8'h70, 60);
        op(0, NBC_OP_READ, 8'h00, 60);
        chk(got, 8'hE0);
        op(0, NBC_OP_CMD, 8'h90, 60);
        op(0, NBC_OP_ADDR, 8'h00, 60);
        chk(i_nbc_flash_model.abyte_q[0], 8'h00);
        op(0, NBC_OP_CMD, 8'h00, 60);
        op(0, NBC_OP_READ, 8'h00, 60);
        chk(got, 8'hE6);
        op(0, NBC_OP_READ, 8'h00, 60);
        chk(got, 8'hE7);
        op(0, NBC_OP_CMD, 8'h30, 12);
        chk(busy, 1'b1);
        chk(req_ready, 1'b0);
        op(0, NBC_OP_READ, 8'h00, 60);
        chk(got, 8'hE4);
        deselect <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cs_n, 1'b1);
        give_verdict();
    end
endmodule : nbc_host_tb_top

// ===== nbc_pkg.sv
package nbc_pkg;
    typedef enum logic [1:0] {
        NBC_OP_CMD = 2'h0,
        NBC_OP_ADDR = 2'h1,
        NBC_OP_WRITE = 2'h2,
        NBC_OP_READ = 2'h3
    } nbc_op_e;

    typedef enum logic [2:0] {
        NBC_ST_IDLE = 3'h0,
        NBC_ST_SETUP = 3'h1,
        NBC_ST_LOW = 3'h3,
        NBC_ST_HIGH = 3'h2,
        NBC_ST_DONE = 3'h6
    } nbc_state_e;

    typedef logic [7:0] nbc_byte_t;
endpackage : nbc_pkg
